// ==== core/cmgr_pkg.sv ====
// Purpose: Shared constants for the clock manager block.
// Assumes: Wishbone byte addresses, 32-bit data words.
// Notes: Feedback modes are coded in the control register.
package cmgr_pkg;
   // Register byte offsets
   localparam logic [7:0] CMGR_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CMGR_ADDR_STATUS = 8'h04;
   localparam logic [7:0] CMGR_ADDR_PHASE = 8'h08;
   localparam logic [7:0] CMGR_ADDR_PERIOD = 8'h0C;
   // Control register fields
   localparam int CMGR_CTRL_RST_INV = 0;
   localparam int CMGR_CTRL_REQ_INV = 1;
   localparam int CMGR_CTRL_DIR_INV = 2;
   localparam int CMGR_CTRL_FB_LSB = 4;
   localparam logic [31:0] CMGR_CTRL_RESET = 32'h0000_0010;
   localparam logic [31:0] CMGR_CTRL_MASK = 32'h0000_0037;
   // Status register fields
   localparam int CMGR_ST_LIMIT = 0;
   localparam int CMGR_ST_IN_STOP = 1;
   localparam int CMGR_ST_FX_STOP = 2;
   localparam int CMGR_ST_LOCKED = 3;
   localparam int CMGR_ST_BUSY = 4;
   // Feedback selection codes
   localparam logic [1:0] CMGR_FB_NONE = 2'h0;
   localparam logic [1:0] CMGR_FB_1X = 2'h1;
   localparam logic [1:0] CMGR_FB_2X = 2'h2;
   // Timing counts in clk_i cycles or reference periods
   localparam int CMGR_LOCK_PERIODS = 4;
   localparam int CMGR_SLIDE_CYCLES = 4;
   localparam int CMGR_STOP_PERIODS = 2;
endpackage : cmgr_pkg

// ==== core/cmgr_sync.sv ====
// Purpose: Two-stage synchroniser for a group of slow inputs.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module cmgr_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   // Two flip-flops in series
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         meta_r <= '0;
         q_o <= '0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : cmgr_sync
`default_nettype wire

// ==== core/cmgr_top.sv ====
// Purpose: Sampled-logic clock manager with quarter phases, doubler, divider,
//          synthesizer, fine phase shifter and status flags.
// Assumes: ref_clock_in period of at least 8 clk_i cycles; pins other than clk_i, rst_b_i and Wishbone asynchronous.
// Notes: One fine step equals one clk_i cycle; outputs are clk_i-quantised.
`timescale 1ns/1ps
`default_nettype none
module cmgr_top
   import cmgr_pkg::*;
#(
   parameter int PW = 12,
   parameter int DIV_X2 = 4,
   parameter int FX_MUL = 4,
   parameter int FX_DIV = 1,
   parameter int PS_MAX = 4
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ref_clock_in_i,
   input wire logic feedback_clock_in_i,
   input wire logic mgr_reset_i,
   input wire logic shift_clock_i,
   input wire logic shift_request_i,
   input wire logic shift_direction_i,
   output logic shift_done_o,
   output logic out_phase_0_o,
   output logic out_phase_90_o,
   output logic out_phase_180_o,
   output logic out_phase_270_o,
   output logic out_double_o,
   output logic out_double_inv_o,
   output logic out_divided_o,
   output logic out_synth_o,
   output logic out_synth_inv_o,
   output logic locked_o,
   output logic [2:0] status_o
);
   typedef enum {CMGR_ACQ, CMGR_LOCK} cmgr_lock_t;
   typedef enum {SH_IDLE, SH_SLIDE, SH_ARM, SH_DONE} cmgr_shift_t;
   localparam int DW = PW + 6;
   localparam int AW = PW + 8;
   localparam logic signed [PW:0] FMAX = (PW+1)'(PS_MAX);
   localparam logic signed [PW:0] FSTEP = (PW+1)'(1);

   // Wrap a signed position into 0..p-1 with one correction
   function automatic logic [PW-1:0] wrap(input logic signed [PW+1:0] v,
                                          input logic [PW-1:0] p);
      logic signed [PW+1:0] r;
      r = v;
      if (r < 0) begin
         r = r + $signed({2'b00, p});
      end else if (r >= $signed({2'b00, p})) begin
         r = r - $signed({2'b00, p});
      end
      return r[PW-1:0];
   endfunction : wrap

   logic [5:0] sync_q;
   logic [31:0] ctrl_r;
   logic ref_d_r, fb_d_r, ps_d_r;
   logic [PW-1:0] cnt_r, period_r, ph_r;
   logic [2:0] match_r;
   logic fb_seen_r, ref_after_lock_r;
   cmgr_lock_t lock_r;
   cmgr_shift_t sh_r;
   logic [2:0] slide_r;
   logic dir_r;
   logic signed [PW:0] fine_r;
   logic [DW-1:0] dv_r;
   logic [AW-1:0] acc_r, fx_idle_r;
   logic fx_r;

   // Synchronise all asynchronous pins
   cmgr_sync #(.W(6)) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i({mgr_reset_i, shift_direction_i, shift_request_i, shift_clock_i,
            feedback_clock_in_i, ref_clock_in_i}),
      .q_o(sync_q)
   );

   // Edge detection and input inversion
   wire [1:0] fb_mode = ctrl_r[CMGR_CTRL_FB_LSB +: 2];
   wire fb_used = (fb_mode != CMGR_FB_NONE);
   wire mgr_rst = sync_q[5] ^ ctrl_r[CMGR_CTRL_RST_INV];
   wire dir_eff = sync_q[4] ^ ctrl_r[CMGR_CTRL_DIR_INV];
   wire req_eff = sync_q[3] ^ ctrl_r[CMGR_CTRL_REQ_INV];
   wire ref_rise = sync_q[0] & ~ref_d_r;
   wire fb_rise = sync_q[1] & ~fb_d_r;
   wire ps_rise = sync_q[2] & ~ps_d_r;
   wire clr = ~rst_b_i | mgr_rst;
   wire locked = (lock_r == CMGR_LOCK);
   wire [PW-1:0] cnt_inc = cnt_r + PW'(1);
   wire period_same = (cnt_inc == period_r);
   wire cnt_sat = &cnt_r;

   // Wishbone decode
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_ctrl = wb_req & wb_we_i & (wb_adr_i == CMGR_ADDR_CTRL) & wb_sel_i[0];
   wire [31:0] status_word = {27'h000_0000, (sh_r != SH_IDLE), locked_o, status_o};
   wire [31:0] rd_mux = (wb_adr_i == CMGR_ADDR_CTRL) ? ctrl_r :
                        (wb_adr_i == CMGR_ADDR_STATUS) ? status_word :
                        (wb_adr_i == CMGR_ADDR_PHASE) ? 32'(fine_r) :
                        (wb_adr_i == CMGR_ADDR_PERIOD) ? 32'(period_r) : 32'h0000_0000;

   // Register slave, one wait state
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ctrl_r <= CMGR_CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
         if (wr_ctrl) begin
            ctrl_r <= wb_dat_i & CMGR_CTRL_MASK;
         end
      end
   end

   // Edge history of sampled clocks
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ref_d_r <= 1'b0;
         fb_d_r <= 1'b0;
         ps_d_r <= 1'b0;
      end else begin
         ref_d_r <= sync_q[0];
         fb_d_r <= sync_q[1];
         ps_d_r <= sync_q[2];
      end
   end

   // Reference period measurement and lock acquisition
   always_ff @(posedge clk_i) begin
      if (clr) begin
         cnt_r <= '0;
         period_r <= '0;
         match_r <= '0;
         fb_seen_r <= 1'b0;
         lock_r <= CMGR_ACQ;
      end else begin
         cnt_r <= ref_rise ? '0 : (cnt_sat ? cnt_r : cnt_inc);
         period_r <= ref_rise ? cnt_inc : period_r;
         fb_seen_r <= fb_seen_r | fb_rise;
         case (lock_r)
            CMGR_ACQ: begin
               if (ref_rise) begin
                  match_r <= period_same ? match_r + 3'd1 : 3'd0;
               end
               if (32'(match_r) >= CMGR_LOCK_PERIODS) begin // Feedback toggles only after lock
                  lock_r <= CMGR_LOCK;
               end
            end
            CMGR_LOCK: lock_r <= CMGR_LOCK;
            default: lock_r <= CMGR_ACQ;
         endcase
      end
   end

   // Phase position; aligned to reference only with feedback in use
   always_ff @(posedge clk_i) begin
      if (clr) begin
         ph_r <= '0;
      end else if (ref_rise && fb_used) begin
         ph_r <= '0;
      end else begin
         ph_r <= (ph_r + PW'(1) >= period_r) ? '0 : ph_r + PW'(1);
      end
   end

   // Quarter-phase and doubler decode
   wire [PW-1:0] half = period_r >> 1;
   wire [PW-1:0] quarter = period_r >> 2;
   wire [PW-1:0] shifted = wrap($signed({2'b00, ph_r}) - (PW+2)'(fine_r), period_r);
   wire [PW-1:0] dbl = (shifted < half) ? PW'(shifted << 1) : PW'((shifted << 1) - period_r);
   wire [PW-1:0] q_pos [4];
   wire [3:0] q_hi;
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_quad
         assign q_pos[k] = wrap($signed({2'b00, shifted}) - $signed({2'b00, PW'(k) * quarter}),
                                period_r);
         assign q_hi[k] = locked & (q_pos[k] < half);
      end
   endgenerate

   // Divider span in clk_i cycles, ratio held in half units
   wire [DW-1:0] dv_span = DW'((DW'(DIV_X2) * DW'(period_r)) >> 1);
   wire [DW-1:0] dv_inc = dv_r + DW'(1);
   // Synthesizer accumulator toggles at twice the target rate
   wire [AW-1:0] fx_thr = AW'(FX_DIV) * AW'(period_r);
   wire [AW-1:0] fx_sum = acc_r + AW'(2 * FX_MUL);
   wire fx_tog = (fx_sum >= fx_thr);

   // Divider and synthesizer counters
   always_ff @(posedge clk_i) begin
      if (clr || !locked) begin
         dv_r <= '0;
         acc_r <= '0;
         fx_r <= 1'b0;
      end else begin
         dv_r <= (dv_inc >= dv_span) ? '0 : dv_inc;
         acc_r <= fx_tog ? fx_sum - fx_thr : fx_sum;
         if (fx_tog) begin
            fx_r <= ~fx_r;
         end
      end
   end

   // Clock outputs from flip-flops, low until lock
   always_ff @(posedge clk_i) begin
      if (clr) begin
         {out_phase_270_o, out_phase_180_o, out_phase_90_o, out_phase_0_o} <= 4'h0;
         out_double_o <= 1'b0;
         out_double_inv_o <= 1'b0;
         out_divided_o <= 1'b0;
         out_synth_o <= 1'b0;
         out_synth_inv_o <= 1'b0;
         locked_o <= 1'b0;
      end else begin
         {out_phase_270_o, out_phase_180_o, out_phase_90_o, out_phase_0_o} <= q_hi;
         out_double_o <= locked & (dbl < half);
         out_double_inv_o <= locked & ~(dbl < half);
         out_divided_o <= locked & (dv_r < (dv_span >> 1));
         out_synth_o <= locked & fx_r;
         out_synth_inv_o <= locked & ~fx_r;
         locked_o <= locked;
      end
   end

   // Fine phase shifter, stepped by the sampled shift clock
   wire at_max = (fine_r == FMAX);
   wire at_min = (fine_r == -FMAX);
   wire blocked = dir_r ? at_max : at_min;
   wire slide_end = (sh_r == SH_SLIDE) && (slide_r == 3'd0);
   always_ff @(posedge clk_i) begin
      if (clr) begin
         sh_r <= SH_IDLE;
         slide_r <= '0;
         dir_r <= 1'b0;
         fine_r <= '0;
         shift_done_o <= 1'b0;
      end else begin
         case (sh_r)
            SH_IDLE: begin
               if (ps_rise && req_eff && locked) begin
                  dir_r <= dir_eff;
                  slide_r <= 3'(CMGR_SLIDE_CYCLES - 1);
                  sh_r <= SH_SLIDE;
               end
            end
            SH_SLIDE: begin
               if (slide_r == 3'd0) begin
                  if (!blocked) begin
                     fine_r <= dir_r ? fine_r + FSTEP : fine_r - FSTEP;
                  end
                  sh_r <= SH_ARM;
               end else begin
                  slide_r <= slide_r - 3'd1;
               end
            end
            SH_ARM: begin
               if (ps_rise) begin
                  shift_done_o <= 1'b1;
                  sh_r <= SH_DONE;
               end
            end
            SH_DONE: begin
               if (ps_rise) begin
                  shift_done_o <= 1'b0;
                  sh_r <= SH_IDLE;
               end
            end
            default: sh_r <= SH_IDLE;
         endcase
      end
   end

   // Status flags
   wire [AW-1:0] stop_lim = AW'(CMGR_STOP_PERIODS) * AW'(period_r);
   always_ff @(posedge clk_i) begin
      if (clr || !locked) begin
         ref_after_lock_r <= 1'b0;
         fx_idle_r <= '0;
         status_o <= 3'h0;
      end else begin
         ref_after_lock_r <= ref_after_lock_r | ref_rise;
         fx_idle_r <= fx_tog ? '0 : ((&fx_idle_r) ? fx_idle_r : fx_idle_r + AW'(1));
         status_o[CMGR_ST_LIMIT] <= at_max | at_min;
         status_o[CMGR_ST_IN_STOP] <= fb_used & fb_seen_r & ref_after_lock_r &
                                      (AW'(cnt_r) > stop_lim);
         status_o[CMGR_ST_FX_STOP] <= (fx_idle_r > fx_thr);
      end
   end

   // Checks on the design's own behaviour
   sequence s_slide_up;
      slide_end && dir_r && !at_max;
   endsequence
   sequence s_slide_down;
      slide_end && !dir_r && !at_min;
   endsequence
   a_done_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (shift_done_o && !ps_rise && !mgr_rst) |=> shift_done_o)
      else $error("done dropped before next shift clock edge");
   a_done_ends: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (shift_done_o && ps_rise) |=> !shift_done_o)
      else $error("done lasted over one shift clock period");
   a_step_up: assert property (@(posedge clk_i) disable iff (clr)
      s_slide_up |=> (fine_r == $past(fine_r) + FSTEP) ##1 (sh_r == SH_ARM))
      else $error("increment did not add one step");
   a_step_down: assert property (@(posedge clk_i) disable iff (clr)
      s_slide_down |=> fine_r == $past(fine_r) - FSTEP)
      else $error("decrement did not remove one step");
   a_limit_hold: assert property (@(posedge clk_i) disable iff (clr)
      (slide_end && blocked) |=> $stable(fine_r) ##[1:1000] shift_done_o)
      else $error("phase moved past limit or no done");
   a_limit_flag: assert property (@(posedge clk_i) disable iff (clr)
      (locked && $past(locked)) |-> status_o[CMGR_ST_LIMIT] == $past(at_max | at_min))
      else $error("limit status disagrees with phase value");
   a_req_ignored: assert property (@(posedge clk_i) disable iff (clr)
      (sh_r == SH_IDLE && ps_rise && !req_eff) |=> sh_r == SH_IDLE)
      else $error("shift started without request");
   a_reset_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mgr_rst |=> (!locked && fine_r == 0 && sh_r == SH_IDLE))
      else $error("manager reset left state behind");
   a_no_lock_out: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !locked_o |-> !(out_phase_0_o || out_double_o || out_synth_o))
      else $error("clock output active while not locked");
   a_double_pair: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      locked_o |-> (out_double_inv_o == !out_double_o))
      else $error("doubled pair not complementary");
   a_synth_pair: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      locked_o |-> (out_synth_inv_o == !out_synth_o))
      else $error("synth pair not complementary");
   a_stop_unlocked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (!locked_o || !fb_used) |=> !status_o[CMGR_ST_IN_STOP] && !(status_o[CMGR_ST_FX_STOP] && !locked_o))
      else $error("stop status set without lock or feedback");
endmodule : cmgr_top
`default_nettype wire

// ==== tb/cmgr_top_tb.sv ====
// Purpose: Self-checking bench for the clock manager top.
// Assumes: Reference 80 ns, clk_i 10 ns, divider ratio 2, synth ratio 4.
// Notes: Feedback is looped from the unshifted or doubled output.
`timescale 1ns/1ps
`default_nettype none
module cmgr_top_tb
   import cmgr_pkg::*;
;
   localparam int PSM = 4;
   logic clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, ref_clk, ref_run, fb_dbl, fb_cut;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i;
   int error_cnt, tests_run;
   wire [31:0] wb_dat_o;
   wire [8:0] ck;
   wire [2:0] status_o;
   wire wb_ack_o, locked_o, shift_done_o, fb, s_clk, s_req, s_dir, m_rst;
   // Feedback from the unshifted or doubled output, or cut
   assign fb = fb_cut ? 1'b0 : (fb_dbl ? ck[4] : ck[0]);
   cmgr_top #(.PS_MAX(PSM)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ref_clock_in_i(ref_clk), .feedback_clock_in_i(fb), .mgr_reset_i(m_rst),
      .shift_clock_i(s_clk), .shift_request_i(s_req), .shift_direction_i(s_dir),
      .shift_done_o(shift_done_o), .out_phase_0_o(ck[0]), .out_phase_90_o(ck[1]),
      .out_phase_180_o(ck[2]), .out_phase_270_o(ck[3]), .out_double_o(ck[4]),
      .out_double_inv_o(ck[5]), .out_divided_o(ck[6]), .out_synth_o(ck[7]),
      .out_synth_inv_o(ck[8]), .locked_o(locked_o), .status_o(status_o));
   cmgr_user u_user (.clk_i(clk_i), .shift_done_i(shift_done_o), .shift_clock_o(s_clk),
      .shift_request_o(s_req), .shift_direction_o(s_dir), .mgr_reset_o(m_rst));
   // System clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Reference clock, unrelated in phase to clk_i, stoppable
   initial begin
      ref_clk = 1'b0;
      #3;
      forever #40 ref_clk = ref_run ? ~ref_clk : ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   // Classic single Wishbone cycle, held until ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 50) error_cnt++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(nm, q, e);
   endtask : rd_chk
   task automatic wait_lock();
      int n;
      n = 0;
      while (locked_o !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      chk("locked", 32'(locked_o), 32'h0000_0001);
   endtask : wait_lock
   task automatic t_regs();
      rd_chk("ctrl", CMGR_ADDR_CTRL, CMGR_CTRL_RESET);
      wr(CMGR_ADDR_CTRL, 32'hFFFF_FFFF);
      rd_chk("ctrl mask", CMGR_ADDR_CTRL, CMGR_CTRL_MASK);
      wr(CMGR_ADDR_STATUS, 32'hFFFF_FFFF);
      rd_chk("status", CMGR_ADDR_STATUS, 32'h0000_0000);
      rd_chk("unmapped", 8'h40, 32'h0000_0000);
      chk("outs", 32'(ck), 32'h0000_0000);
      wr(CMGR_ADDR_CTRL, CMGR_CTRL_RESET);
      $display("test regs done");
   endtask : t_regs
   // Rates, duty and phase relations over 32 cycles
   task automatic t_wave();
      logic [8:0] s [0:32];
      int hi [9];
      int rs [9];
      int er [9] = '{4, 4, 4, 4, 8, 8, 2, 16, 16};
      for (int k = 0; k < 33; k++) begin
         @(posedge clk_i);
         s[k] = ck;
      end
      for (int b = 0; b < 9; b++) begin
         hi[b] = 0;
         rs[b] = 0;
         for (int k = 1; k < 33; k++) begin
            hi[b] += s[k][b];
            rs[b] += s[k][b] & !s[k-1][b];
         end
         chk("duty", hi[b], 16);
         chk("rate", rs[b], er[b]);
      end
      for (int k = 2; k < 33; k++) begin
         chk("q90", s[k][1], s[k-2][0]);
         chk("q180", s[k][2], !s[k][0]);
         chk("q270", s[k][3], !s[k][1]);
         chk("x2 inv", s[k][5], !s[k][4]);
         chk("fx inv", s[k][8], !s[k][7]);
      end
      $display("test wave done");
   endtask : t_wave
   task automatic sh(input logic r, input logic i, input logic d, input int nd_e,
                     input logic [31:0] ph);
      int nd;
      u_user.shift(r, i, d, nd);
      chk("done", nd, nd_e);
      rd_chk("phase", CMGR_ADDR_PHASE, ph);
   endtask : sh
   task automatic t_shift();
      sh(1'b1, 1'b0, 1'b1, 1, 32'h0000_0001);
      sh(1'b0, 1'b0, 1'b1, 0, 32'h0000_0001);
      sh(1'b1, 1'b0, 1'b0, 1, 32'h0000_0000);
      sh(1'b1, 1'b0, 1'b0, 1, 32'hFFFF_FFFF);
      for (int i = 0; i <= PSM; i++) sh(1'b1, 1'b0, 1'b1, 1, 32'(i));
      chk("limit", 32'(status_o[0]), 32'h0000_0001);
      sh(1'b1, 1'b0, 1'b1, 1, 32'(PSM));
      sh(1'b1, 1'b0, 1'b0, 1, 32'(PSM - 1));
      chk("limit", 32'(status_o[0]), 32'h0000_0000);
      wr(CMGR_ADDR_CTRL, 32'h0000_0016);
      sh(1'b0, 1'b1, 1'b1, 1, 32'(PSM - 2));
      wr(CMGR_ADDR_CTRL, CMGR_CTRL_RESET);
      $display("test shift done");
   endtask : t_shift
   // Manager reset, then relock in a given feedback mode
   task automatic t_fb(input logic [1:0] m, input logic dbl, input logic cut);
      fb_dbl <= dbl;
      fb_cut <= cut;
      wr(CMGR_ADDR_CTRL, 32'(m) << CMGR_CTRL_FB_LSB);
      u_user.pulse_reset();
      chk("unlocked", 32'(locked_o), 32'h0000_0000);
      rd_chk("phase rst", CMGR_ADDR_PHASE, 32'h0000_0000);
      wait_lock();
      $display("test feedback done");
   endtask : t_fb
   task automatic t_stop();
      chk("status run", 32'(status_o), 32'h0000_0000);
      rd_chk("status lock", CMGR_ADDR_STATUS, 32'(1) << CMGR_ST_LOCKED);
      // Reference of 80 ns measures as 8 clk_i cycles
      rd_chk("period", CMGR_ADDR_PERIOD, 32'h0000_0008);
      ref_run = 1'b0;
      repeat (100) @(posedge clk_i);
      chk("in stop", 32'(status_o[1]), 32'h0000_0001);
      chk("still lock", 32'(locked_o), 32'h0000_0001);
      ref_run = 1'b1;
      $display("test stop done");
   endtask : t_stop
   // Watchdog
   initial begin
      #800_000;
      error_cnt++;
      results();
   end
   // Main sequence
   initial begin
      error_cnt = 0;
      tests_run = 0;
      rst_b_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0000_0000;
      ref_run = 1'b1;
      fb_dbl = 1'b0;
      fb_cut = 1'b0;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      wait_lock();
      t_wave();
      t_shift();
      t_fb(CMGR_FB_1X, 1'b0, 1'b0);
      t_fb(CMGR_FB_NONE, 1'b0, 1'b1);
      t_fb(CMGR_FB_2X, 1'b1, 1'b0);
      t_wave();
      t_fb(CMGR_FB_1X, 1'b0, 1'b0);
      t_stop();
      results();
   end
endmodule : cmgr_top_tb
`default_nettype wire

// ==== tb/cmgr_user.sv ====
// Purpose: User-side driver of the manager reset and fine shift pins.
// Assumes: Shift clock period of 8 clk_i cycles, idle low between operations.
// Notes: Done is sampled just before each shift clock rise.
`timescale 1ns/1ps
`default_nettype none
module cmgr_user (
   input wire logic clk_i,
   input wire logic shift_done_i,
   output logic shift_clock_o,
   output logic shift_request_o,
   output logic shift_direction_o,
   output logic mgr_reset_o
);
   logic req_idle;
   // Idle levels at time zero
   initial begin
      shift_clock_o = 1'b0;
      shift_request_o = 1'b0;
      shift_direction_o = 1'b0;
      mgr_reset_o = 1'b0;
      req_idle = 1'b0;
   end
   // Reset held four reference periods, longer than the minimum of three
   task automatic pulse_reset();
      mgr_reset_o <= 1'b1;
      repeat (32) @(posedge clk_i);
      mgr_reset_o <= 1'b0;
   endtask : pulse_reset
   // One shift clock period; request set to its idle level after the rise
   task automatic tick(inout int nd);
      shift_clock_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      shift_clock_o <= 1'b0;
      shift_request_o <= req_idle;
      shift_direction_o <= ~shift_direction_o;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      if (shift_done_i === 1'b1) nd++;
      @(posedge clk_i);
   endtask : tick
   // Full operation: setup, five shift periods, done pulses counted
   task automatic shift(input logic req, input logic idle, input logic dir, output int nd);
      nd = 0;
      req_idle = idle;
      shift_request_o <= req;
      shift_direction_o <= dir;
      repeat (2) @(posedge clk_i);
      repeat (5) tick(nd);
   endtask : shift
endmodule : cmgr_user
`default_nettype wire
